// ===== verilog/mise_pkg.sv
// package: opcodes, widths and cycle counts of the instruction subset unit
`default_nettype none
package mise_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 11;
	localparam int REG_AW = 7;
	localparam int BIT_AW = 3;
	localparam int PAGE_LO = 0;
	localparam int PAGE_HI = 2;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [10:0] PC_RESET = 11'h000;
	localparam logic [10:0] PC_STEP = 11'h001;
	localparam logic [7:0] TBL_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BIT = 8'h01;
	localparam logic [6:0] WADDR_RESET = 7'h00;
	localparam logic ZERO_RESET = 1'b0;
	// cycles per instruction
	localparam int CYC_AND = 1;
	localparam int CYC_BSET = 1;
	localparam int CYC_TEST = 1;
	localparam int CYC_SKIP = 2;
	localparam int CYC_CALL = 2;
	typedef enum logic [2:0] {
		MISE_OP_NONE,
		MISE_OP_AND_IMM,
		MISE_OP_BIT_SET,
		MISE_OP_TEST_SKIP,
		MISE_OP_CALL_IND
	} mise_op_t;
endpackage
`default_nettype wire

// ===== verilog/mise_bit_mask.sv
// one-hot bit mask from a bit index
`timescale 1ns/1ps
`default_nettype none
module mise_bit_mask (
	// index in
	input  wire logic [2:0] index,
	// mask out
	output logic      [7:0] mask
);
	assign mask = mise_pkg::ONE_BIT << index;
endmodule
`default_nettype wire

// ===== verilog/mise_exec.sv
// execute stage for and-immediate, bit-set, test-skip and indirect call
`timescale 1ns/1ps
`default_nettype none
module mise_exec (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	// decoded instruction
	input  wire logic                  op_valid,
	input  wire mise_pkg::mise_op_t    op,
	input  wire logic [7:0]            immediate,
	input  wire logic [6:0]            reg_addr,
	input  wire logic [2:0]            bit_index,
	// register file and program counter
	input  wire logic [7:0]            reg_rdata,
	input  wire logic [10:0]           pc,
	input  wire logic [7:0]            table_high_page,
	// accumulator writes by the rest of the core
	input  wire logic                  acc_load,
	input  wire logic [7:0]            acc_load_data,
	// results
	output logic      [7:0]            accumulator,
	output logic                       zero_flag,
	output logic                       zero_we,
	output logic                       reg_we,
	output logic      [6:0]            reg_waddr,
	output logic      [7:0]            reg_wdata,
	output logic                       discard_next,
	output logic                       push_we,
	output logic      [10:0]           push_addr,
	output logic                       pc_load,
	output logic      [10:0]           pc_target,
	output logic                       busy
);
	// ------------------------------------------------
	// state
	// ------------------------------------------------
	typedef enum logic [1:0] {
		MISE_ST_ISSUE,
		MISE_ST_SECOND
	} mise_state_t;

	mise_state_t state, next_state;
	logic [7:0]  next_accumulator;
	logic        next_zero_flag;
	logic        next_zero_we;
	logic        next_reg_we;
	logic [6:0]  next_reg_waddr;
	logic [7:0]  next_reg_wdata;
	logic        next_discard_next;
	logic        next_push_we;
	logic [10:0] next_push_addr;
	logic        next_pc_load;
	logic [10:0] next_pc_target;
	logic        next_busy;
	logic [7:0]  mask;
	logic [7:0]  and_result;
	logic        take;

	mise_bit_mask u_mask (
		.index (bit_index),
		.mask  (mask)
	);

	assign and_result = accumulator & immediate;
	// new ops are taken only in the issue state; second cycles stall decode
	assign take = op_valid && (state == MISE_ST_ISSUE);

	// ------------------------------------------------
	// next state
	// ------------------------------------------------
	always_comb begin
		next_state = MISE_ST_ISSUE;
		next_accumulator = accumulator;
		next_zero_flag = zero_flag;
		next_zero_we = 1'b0;
		next_reg_we = 1'b0;
		next_reg_waddr = reg_waddr;
		next_reg_wdata = reg_wdata;
		next_discard_next = 1'b0;
		next_push_we = 1'b0;
		next_push_addr = push_addr;
		next_pc_load = 1'b0;
		next_pc_target = pc_target;
		next_busy = 1'b0;
		// other instructions own the accumulator too; an and taken
		// in the same cycle overrides the load below
		if (acc_load) begin
			next_accumulator = acc_load_data;
		end
		case (state)
		MISE_ST_ISSUE: begin
			if (take) begin
				case (op)
				mise_pkg::MISE_OP_AND_IMM: begin
					next_accumulator = and_result;
					next_zero_flag = (and_result == mise_pkg::ZERO_BYTE);
					next_zero_we = 1'b1;
				end
				mise_pkg::MISE_OP_BIT_SET: begin
					next_reg_we = 1'b1;
					next_reg_waddr = reg_addr;
					next_reg_wdata = reg_rdata | mask;
				end
				mise_pkg::MISE_OP_TEST_SKIP: begin
					if ((reg_rdata & mask) == mise_pkg::ZERO_BYTE) begin
						// fetched word becomes a nop, costing a second cycle
						next_discard_next = 1'b1;
						next_busy = 1'b1;
						next_state = MISE_ST_SECOND;
					end
				end
				mise_pkg::MISE_OP_CALL_IND: begin
					next_push_we = 1'b1;
					next_push_addr = pc + mise_pkg::PC_STEP;
					next_pc_load = 1'b1;
					next_pc_target = {table_high_page[mise_pkg::PAGE_HI:
						mise_pkg::PAGE_LO], accumulator};
					next_busy = 1'b1;
					next_state = MISE_ST_SECOND;
				end
				default: begin
					next_state = MISE_ST_ISSUE;
				end
				endcase
			end
		end
		MISE_ST_SECOND: begin
			next_state = MISE_ST_ISSUE;
		end
		default: begin
			next_state = MISE_ST_ISSUE;
		end
		endcase
	end

	// ------------------------------------------------
	// registers
	// ------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= MISE_ST_ISSUE;
			accumulator <= mise_pkg::ACC_RESET;
			zero_flag <= mise_pkg::ZERO_RESET;
			zero_we <= 1'b0;
			reg_we <= 1'b0;
			reg_waddr <= mise_pkg::WADDR_RESET;
			reg_wdata <= mise_pkg::ZERO_BYTE;
			discard_next <= 1'b0;
			push_we <= 1'b0;
			push_addr <= mise_pkg::PC_RESET;
			pc_load <= 1'b0;
			pc_target <= mise_pkg::PC_RESET;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			accumulator <= next_accumulator;
			zero_flag <= next_zero_flag;
			zero_we <= next_zero_we;
			reg_we <= next_reg_we;
			reg_waddr <= next_reg_waddr;
			reg_wdata <= next_reg_wdata;
			discard_next <= next_discard_next;
			push_we <= next_push_we;
			push_addr <= next_push_addr;
			pc_load <= next_pc_load;
			pc_target <= next_pc_target;
			busy <= next_busy;
		end
	end

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	sequence call_taken_s;
		take && op == mise_pkg::MISE_OP_CALL_IND;
	endsequence
	sequence call_done_s;
		push_we && pc_load && busy ##1 !busy && !push_we;
	endsequence
	sequence skip_taken_s;
		take && op == mise_pkg::MISE_OP_TEST_SKIP;
	endsequence
	sequence skip_done_s;
		discard_next && busy ##1 !busy && !discard_next;
	endsequence

	and_result_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(take && op == mise_pkg::MISE_OP_AND_IMM) |=> zero_we &&
		accumulator == ($past(accumulator) & $past(immediate)))
		else $error("and result wrong");
	acc_load_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(acc_load && !(take && op == mise_pkg::MISE_OP_AND_IMM)) |=>
		accumulator == $past(acc_load_data) && !zero_we)
		else $error("accumulator load wrong");
	zero_flag_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		zero_we |-> zero_flag == (accumulator == 8'h00))
		else $error("zero flag wrong");
	zero_hold_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		!zero_we |-> $stable(zero_flag))
		else $error("zero flag moved");
	bit_set_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(take && op == mise_pkg::MISE_OP_BIT_SET) |=> reg_we &&
		reg_wdata[$past(bit_index)] &&
		((reg_wdata ^ $past(reg_rdata)) & ~$past(mask)) == 8'h00)
		else $error("bit set wrong");
	skip_clear_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		skip_taken_s |=> discard_next == !$past(reg_rdata[bit_index]))
		else $error("skip decision wrong");
	skip_len_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		discard_next |-> skip_done_s)
		else $error("skip not two cycles");
	stall_quiet_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		busy |=> !zero_we && !reg_we && !push_we && !discard_next)
		else $error("op taken while stalled");
	call_seq_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		call_taken_s |=> call_done_s)
		else $error("call not two cycles");
	call_push_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		call_taken_s |=> push_addr == $past(pc) + 11'h001 && !zero_we)
		else $error("return address wrong");
	call_target_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		call_taken_s |=> pc_target ==
		{$past(table_high_page[2:0]), $past(accumulator)})
		else $error("call target wrong");
endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking testbench of the instruction subset execute unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic               clock = 1'b0;
	logic               arst_n = 1'b0;
	logic               op_valid = 1'b0;
	mise_pkg::mise_op_t op = mise_pkg::MISE_OP_NONE;
	logic [7:0]         immediate = 8'h00;
	logic [6:0]         reg_addr = 7'h00;
	logic [2:0]         bit_index = 3'h0;
	logic [7:0]         reg_rdata = 8'h00;
	logic [10:0]        pc = 11'h000;
	logic [7:0]         table_high_page = 8'h00;
	logic               acc_load = 1'b0;
	logic [7:0]         acc_load_data = 8'h00;
	logic [7:0]         accumulator;
	logic [10:0]        push_addr;
	logic [10:0]        pc_target;
	logic [6:0]         reg_waddr;
	logic [7:0]         reg_wdata;
	logic               zero_flag;
	logic               zero_we;
	logic               reg_we;
	logic               discard_next;
	logic               push_we;
	logic               pc_load;
	logic               busy;
	int                 fails = 0;
	int                 checks = 0;

	mise_exec mise_exec_inst (.clock, .arst_n, .op_valid, .op, .immediate,
		.reg_addr, .bit_index, .reg_rdata, .pc, .table_high_page,
		.acc_load, .acc_load_data,
		.accumulator, .zero_flag, .zero_we, .reg_we, .reg_waddr,
		.reg_wdata, .discard_next, .push_we, .push_addr, .pc_load,
		.pc_target, .busy);

	always #2 clock = ~clock;

	task automatic chk(input string n, input logic [10:0] e, g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// present an op at the next edge; it is taken one edge later
	task automatic go(input mise_pkg::mise_op_t o);
		@(posedge clock);
		op_valid <= 1'b1;
		op <= o;
		@(posedge clock);
		op_valid <= 1'b0;
		#1;
	endtask

	// write the accumulator as another instruction of the core would
	task automatic load_acc(input logic [7:0] v);
		@(posedge clock);
		acc_load <= 1'b1;
		acc_load_data <= v;
		@(posedge clock);
		acc_load <= 1'b0;
		#1;
	endtask

	task automatic t_and;
		load_acc(8'h5A);
		chk("acc load", 11'h05A, accumulator);
		immediate <= 8'h05;
		go(mise_pkg::MISE_OP_AND_IMM);
		chk("acc", 11'h000, accumulator);
		chk("zero", 11'h001, zero_flag);
		chk("zero_we", 11'h001, zero_we);
		chk("reg_we", 11'h000, reg_we);
		@(posedge clock);
		#1;
		chk("zero_we end", 11'h000, zero_we);
		load_acc(8'h5A);
		chk("zero kept", 11'h001, zero_flag);
		immediate <= 8'hAF;
		go(mise_pkg::MISE_OP_AND_IMM);
		chk("acc nonzero", 11'h00A, accumulator);
		chk("zero clear", 11'h000, zero_flag);
		chk("zero_we 2", 11'h001, zero_we);
		$display("test and done");
	endtask

	task automatic t_bset;
		for (int i = 0; i < 8; i++) begin
			reg_addr <= 7'h55;
			bit_index <= 3'(i);
			reg_rdata <= 8'h5A;
			go(mise_pkg::MISE_OP_BIT_SET);
			chk("wdata", 11'(8'h5A | (8'h01 << i)), reg_wdata);
			chk("waddr", 11'h055, reg_waddr);
			chk("reg_we", 11'h001, reg_we);
			chk("zero_we", 11'h000, zero_we);
			chk("zero", 11'h000, zero_flag);
		end
		$display("test bit set done");
	endtask

	task automatic t_skip;
		reg_rdata <= 8'h5A;
		bit_index <= 3'h2;
		@(posedge clock);
		op_valid <= 1'b1;
		op <= mise_pkg::MISE_OP_TEST_SKIP;
		@(posedge clock);
		op <= mise_pkg::MISE_OP_AND_IMM;
		#1;
		chk("discard", 11'h001, discard_next);
		chk("busy", 11'h001, busy);
		@(posedge clock);
		op_valid <= 1'b0;
		#1;
		chk("refused", 11'h000, zero_we);
		chk("discard end", 11'h000, discard_next);
		bit_index <= 3'h3;
		go(mise_pkg::MISE_OP_TEST_SKIP);
		chk("no discard", 11'h000, discard_next);
		chk("no busy", 11'h000, busy);
		$display("test skip done");
	endtask

	task automatic t_call;
		pc <= 11'h0A0;
		table_high_page <= 8'hFA;
		load_acc(8'h34);
		go(mise_pkg::MISE_OP_CALL_IND);
		chk("push_we", 11'h001, push_we);
		chk("push_addr", 11'h0A1, push_addr);
		chk("busy", 11'h001, busy);
		chk("pc_load", 11'h001, pc_load);
		chk("target", 11'h234, pc_target);
		chk("zero", 11'h000, zero_flag);
		@(posedge clock);
		#1;
		chk("busy end", 11'h000, busy);
		chk("push end", 11'h000, push_we);
		chk("load end", 11'h000, pc_load);
		$display("test call done");
	endtask

	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		chk("acc reset", 11'h000, accumulator);
		chk("zero reset", 11'h000, zero_flag);
		t_and;
		t_bset;
		t_skip;
		t_call;
		report_and_stop;
	end

	// whole run needs well under a thousand cycles
	initial begin
		#20000;
		fails++;
		report_and_stop;
	end
endmodule
`default_nettype wire
